/* logic/fpo_pkg.sv */
// constants and types of the flash protection, otp and reset block
// assumes a 50 MHz system clock and an ahb-lite register window
//
// Overview of operation
// RULE1 - lock-down is 0060h then 002Fh
// RULE2 - id read at base+02h gives lock bits
// RULE3 - otp: 16x128b, 2x64b, two lock words
// RULE4 - lock0 guards blocks 0-1, lock1 2-17
// RULE5 - otp bits only ever go 1 to 0
// RULE6 - block 0 factory value, factory locked
// RULE7 - lock bit 0 locks; else reprogrammable
// RULE8 - otp locks can never be undone
// RULE9 - program to locked block: bits 4,1
// RULE10 - program outside otp area: bit 4
// RULE11 - 16-bit words, only zeros change bits
// RULE12 - otp program is 00C0h then data word
// RULE13 - otp setup switches partition to status
// RULE14 - otp program ignores suspend requests
// RULE15 - otp read via id mode at offset
// RULE16 - low program supply inhibits array writes
// RULE17 - in reset: idle, inputs ignored, outputs off
// RULE18 - reset exit: array read, status 0080h
// RULE19 - reset aborts a running program
// RULE20 - host holds reset low 100 ns
// RULE21 - reset done in 25 us if busy
// RULE22 - host holds reset over power changes
// RULE23 - 0001h locks, 00D0h unlocks after 0060h
// RULE24 - reset exit: all locked, no lock-down
// RULE25 - write protect gates and restores lock-down
// RULE26 - lock state read in id mode
// RULE27 - confirm needs setup on same block
package fpo_pkg;
  localparam int CLK_MHZ = 50;
  localparam int RST_MIN_NS = 100;
  localparam int RST_ABORT_US = 25;
  // least time rounds up, longest time rounds down
  localparam int RST_MIN_CYC = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_ABORT_CYC = RST_ABORT_US * CLK_MHZ;
  localparam logic [15:0] CMD_LOCK_SETUP = 16'h0060;
  localparam logic [15:0] CMD_LOCKDOWN = 16'h002F;
  localparam logic [15:0] CMD_LOCK = 16'h0001;
  localparam logic [15:0] CMD_UNLOCK = 16'h00D0;
  localparam logic [15:0] CMD_OTP_SETUP = 16'h00C0;
  localparam logic [15:0] CMD_READ_ARRAY = 16'h00FF;
  localparam logic [15:0] CMD_READ_STATUS = 16'h0070;
  localparam logic [15:0] CMD_IDENTIFICATION_READ = 16'h0090;
  localparam logic [15:0] CMD_CLEAR_STATUS = 16'h0050;
  localparam logic [15:0] CMD_SUSPEND = 16'h00B0;
  localparam logic [15:0] ARRAY_FILL = 16'hFFFF;
  localparam int SR_READY_BIT = 7;
  localparam int SR_PROG_ERR_BIT = 4;
  localparam int SR_LOCK_ERR_BIT = 1;
  localparam logic [7:0] SR_RESET = 8'h80;
  localparam int ID_LOCK_OFS = 2;
  localparam int OTP_ID_BASE = 128;
  localparam int OTP_WORDS = 138;
  localparam int OTP_LOCK0_IDX = 0;
  localparam int OTP_SMALL_FIRST = 1;
  localparam int OTP_SMALL_WORDS = 4;
  localparam int OTP_LOCK1_IDX = 9;
  localparam int OTP_BIG_FIRST = 10;
  localparam int OTP_BIG_WORDS = 8;
  localparam logic [15:0] OTP_LOCK0_INIT = 16'hFFFE;
  localparam logic [7:0] REG_ADDR = 8'h00;
  localparam logic [7:0] REG_DATA = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0C;
  localparam int CTRL_RST_N_BIT = 0;
  localparam int CTRL_WP_N_BIT = 1;
  localparam int CTRL_VPP_OK_BIT = 2;
  localparam logic [2:0] CTRL_INIT = 3'h3;
  localparam int STAT_RST_DONE_BIT = 8;
  localparam int STAT_BUSY_BIT = 9;
  localparam logic [1:0] RD_WAIT = 2'h1;
  typedef enum logic [1:0] {RM_ARRAY, RM_STATUS, RM_ID} fpo_rmode_type;
  typedef enum logic [1:0] {
    CS_IDLE, CS_LOCK_SETUP, CS_OTP_SETUP, CS_OTP_BUSY
  } fpo_cstate_type;
endpackage : fpo_pkg

/* logic/fpo_otp_mem.sv */
// one-time programmable word store with and-only writes
// assumes the system reset stands for the factory state
`timescale 1ns/10ps
module fpo_otp_mem #(
  parameter int WORDS = fpo_pkg::OTP_WORDS,
  parameter logic [63:0] UID = 64'h0123_4567_89AB_CDEF // arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_we,
  input wire logic [7:0] i_waddr,
  input wire logic [15:0] i_wdata,
  input wire logic [7:0] i_raddr,
  output logic [15:0] o_rdata,
  output logic [15:0] o_lock0,
  output logic [15:0] o_lock1
);
  logic [15:0] mem_ff [WORDS]; // RULE3
  logic [15:0] rdata_ff; // registered read port

  // factory image: ones, uid in block 0, block 0 locked
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_ff[i] <= 16'hFFFF; // RULE6
      end
      for (int i = 0; i < fpo_pkg::OTP_SMALL_WORDS; i++) begin
        mem_ff[fpo_pkg::OTP_SMALL_FIRST + i] <= UID[16*i +: 16]; // RULE6
      end
      mem_ff[fpo_pkg::OTP_LOCK0_IDX] <= fpo_pkg::OTP_LOCK0_INIT; // RULE6
    end else if (i_we && (int'(i_waddr) < WORDS)) begin
      // zeros clear bits, ones keep them; nothing sets a bit
      mem_ff[i_waddr] <= mem_ff[i_waddr] & i_wdata; // RULE5 RULE11 RULE8
    end
  end

  // read data out of a register
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rdata_ff <= 16'h0000;
    end else if (int'(i_raddr) < WORDS) begin
      rdata_ff <= mem_ff[i_raddr];
    end else begin
      rdata_ff <= 16'hFFFF;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_lock0 = mem_ff[fpo_pkg::OTP_LOCK0_IDX];
  assign o_lock1 = mem_ff[fpo_pkg::OTP_LOCK1_IDX];
endmodule : fpo_otp_mem

/* logic/fpo_top.sv */
// block lock, otp area and reset control of a partitioned flash
// assumes a single ahb-lite master and that hready is our hreadyout
`timescale 1ns/10ps
module fpo_top #(
  parameter int ADDR_W = 26,
  parameter int BLK_SHIFT = 17,
  parameter int PART_SHIFT = 23,
  parameter int OTP_PROG_CYC = 100,
  parameter int RST_ABORT_CYC = fpo_pkg::RST_ABORT_CYC
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic o_data_oe,
  output logic o_wait_oe,
  output logic o_pe_inhibit
);
  localparam int NUM_BLOCKS = 1 << (ADDR_W - BLK_SHIFT);
  localparam int NUM_PARTS = 1 << (ADDR_W - PART_SHIFT);
  localparam int BW = ADDR_W - BLK_SHIFT;
  localparam int PW = ADDR_W - PART_SHIFT;
  localparam int RCW = $clog2(RST_ABORT_CYC + 1);
  localparam int BCW = $clog2(OTP_PROG_CYC + 1);

  // ahb data-phase bookkeeping
  logic dp_valid_ff; // a transfer is in its data phase
  logic dp_write_ff; // that transfer is a write
  logic [7:0] dp_addr_ff; // its register offset
  logic rd_pend_ff; // flash read waiting on the otp store
  logic [1:0] rd_wait_ff; // wait states left
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic hresp_ff;
  // software-visible registers
  logic [ADDR_W-1:0] cmd_addr_ff; // flash word address
  logic [2:0] ctrl_ff; // reset_n, write protect_n, supply ok
  // command machine
  fpo_pkg::fpo_cstate_type state_ff;
  logic [BW-1:0] setup_blk_ff; // block named by the setup word
  logic prog_err_ff; // status word bit 4
  logic lock_err_ff; // status word bit 1
  logic [BCW-1:0] busy_cnt_ff; // otp program time left
  logic [7:0] otp_widx_ff; // otp word being programmed
  logic [15:0] otp_wdata_ff; // its data
  // per-partition read mode and per-block lock state
  fpo_pkg::fpo_rmode_type mode_ff [NUM_PARTS];
  logic [NUM_BLOCKS-1:0] lock_ff;
  logic [NUM_BLOCKS-1:0] ldn_ff;
  // reset sequencing
  logic rst_prev_ff;
  logic [RCW-1:0] rst_cnt_ff;
  logic rst_done_ff;
  // pin-facing outputs
  logic data_oe_ff;
  logic wait_oe_ff;
  logic pe_inhibit_ff;

  // combinational helpers
  logic flash_rst; // flash reset pin asserted
  logic wp_on; // write protect asserted
  logic vpp_ok; // program supply above lockout level
  logic wr_strobe; // register write in data phase
  logic cmd_we; // one bus write cycle to the flash
  logic [15:0] cmd_word;
  logic [BW-1:0] cur_blk;
  logic [PW-1:0] cur_part;
  logic [BLK_SHIFT-1:0] blk_ofs;
  logic [PART_SHIFT-1:0] part_ofs;
  logic [PART_SHIFT-1:0] otp_rel;
  logic in_otp; // address falls inside the otp area
  logic [7:0] otp_idx;
  logic [15:0] otp_rdata;
  logic [15:0] otp_lock0;
  logic [15:0] otp_lock1;
  logic mem_we;
  logic [7:0] sr_word;
  logic [15:0] flash_rd;

  // true when an otp data word sits in a locked block
  function automatic logic otp_word_locked(
    input logic [7:0] idx,
    input logic [15:0] l0,
    input logic [15:0] l1
  );
    int blk;
    otp_word_locked = 1'b0;
    blk = 0;
    // the lock words themselves stay programmable bit by bit
    if (int'(idx) == fpo_pkg::OTP_LOCK0_IDX ||
        int'(idx) == fpo_pkg::OTP_LOCK1_IDX) begin
      otp_word_locked = 1'b0;
    end else if (int'(idx) < fpo_pkg::OTP_LOCK1_IDX) begin
      blk = (int'(idx) - fpo_pkg::OTP_SMALL_FIRST) /
            fpo_pkg::OTP_SMALL_WORDS;
      otp_word_locked = ~l0[blk[3:0]]; // RULE4 RULE7
    end else begin
      blk = (int'(idx) - fpo_pkg::OTP_BIG_FIRST) / fpo_pkg::OTP_BIG_WORDS;
      otp_word_locked = ~l1[blk[3:0]]; // RULE4 RULE7
    end
  endfunction : otp_word_locked

  // readable ahb registers; unmapped offsets read zero
  function automatic logic [31:0] reg_rd(input logic [7:0] ofs);
    reg_rd = 32'h0000_0000;
    case (ofs)
      fpo_pkg::REG_ADDR: reg_rd[ADDR_W-1:0] = cmd_addr_ff;
      fpo_pkg::REG_STATUS: begin
        reg_rd[7:0] = sr_word;
        reg_rd[fpo_pkg::STAT_RST_DONE_BIT] = rst_done_ff;
        reg_rd[fpo_pkg::STAT_BUSY_BIT] =
          (state_ff == fpo_pkg::CS_OTP_BUSY);
      end
      fpo_pkg::REG_CTRL: reg_rd[2:0] = ctrl_ff;
      default: reg_rd = 32'h0000_0000;
    endcase
  endfunction : reg_rd

  assign flash_rst = ~ctrl_ff[fpo_pkg::CTRL_RST_N_BIT];
  assign wp_on = ~ctrl_ff[fpo_pkg::CTRL_WP_N_BIT];
  assign vpp_ok = ctrl_ff[fpo_pkg::CTRL_VPP_OK_BIT];
  assign wr_strobe = dp_valid_ff & dp_write_ff & hreadyout_ff;
  // while the flash is in reset its bus writes are dropped
  assign cmd_we = wr_strobe & (dp_addr_ff == fpo_pkg::REG_DATA) &
                  ~flash_rst; // RULE17
  assign cmd_word = i_hwdata[15:0];
  assign cur_blk = cmd_addr_ff[ADDR_W-1:BLK_SHIFT];
  assign cur_part = cmd_addr_ff[ADDR_W-1:PART_SHIFT];
  assign blk_ofs = cmd_addr_ff[BLK_SHIFT-1:0];
  assign part_ofs = cmd_addr_ff[PART_SHIFT-1:0];
  assign otp_rel = part_ofs - PART_SHIFT'(fpo_pkg::OTP_ID_BASE);
  assign in_otp = (part_ofs >= PART_SHIFT'(fpo_pkg::OTP_ID_BASE)) &&
                  (otp_rel < PART_SHIFT'(fpo_pkg::OTP_WORDS));
  assign otp_idx = otp_rel[7:0];
  // the write lands only at the end of the program time
  assign mem_we = (state_ff == fpo_pkg::CS_OTP_BUSY) &&
                  (busy_cnt_ff == '0) && ~flash_rst; // RULE19

  // status word: ready, program error, lock error
  always_comb begin
    sr_word = 8'h00;
    sr_word[fpo_pkg::SR_READY_BIT] = (state_ff != fpo_pkg::CS_OTP_BUSY);
    sr_word[fpo_pkg::SR_PROG_ERR_BIT] = prog_err_ff;
    sr_word[fpo_pkg::SR_LOCK_ERR_BIT] = lock_err_ff;
  end

  // flash read data as the addressed partition's mode selects
  always_comb begin
    flash_rd = 16'h0000;
    if (!flash_rst) begin
      case (mode_ff[cur_part])
        fpo_pkg::RM_STATUS: flash_rd = {8'h00, sr_word};
        fpo_pkg::RM_ID: begin
          if (in_otp) begin
            flash_rd = otp_rdata; // RULE15
          end else if (blk_ofs == BLK_SHIFT'(fpo_pkg::ID_LOCK_OFS)) begin
            flash_rd = {14'h0000, ldn_ff[cur_blk], lock_ff[cur_blk]}; // RULE2 RULE26
          end
        end
        // main array data lives outside this block
        fpo_pkg::RM_ARRAY: flash_rd = fpo_pkg::ARRAY_FILL;
        default: flash_rd = 16'h0000;
      endcase
    end
  end

  // otp word store
  fpo_otp_mem #(
    .WORDS(fpo_pkg::OTP_WORDS)
  ) u_otp (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_we(mem_we),
    .i_waddr(otp_widx_ff),
    .i_wdata(otp_wdata_ff),
    .i_raddr(otp_idx),
    .o_rdata(otp_rdata),
    .o_lock0(otp_lock0),
    .o_lock1(otp_lock1)
  );

  // ahb slave: zero-wait registers, two wait states on flash reads
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      dp_valid_ff <= 1'b0;
      dp_write_ff <= 1'b0;
      dp_addr_ff <= 8'h00;
      rd_pend_ff <= 1'b0;
      rd_wait_ff <= 2'h0;
      hrdata_ff <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else if (rd_pend_ff) begin
      // the otp store answers a cycle after the address settles
      if (rd_wait_ff != 2'h0) begin
        rd_wait_ff <= rd_wait_ff - 2'h1;
      end else begin
        hrdata_ff <= {16'h0000, flash_rd};
        hreadyout_ff <= 1'b1;
        rd_pend_ff <= 1'b0;
      end
    end else if (i_hready) begin
      dp_valid_ff <= i_hsel & i_htrans[1];
      dp_write_ff <= i_hwrite;
      dp_addr_ff <= i_haddr[7:0];
      if (i_hsel && i_htrans[1] && !i_hwrite) begin
        if (i_haddr[7:0] == fpo_pkg::REG_DATA) begin
          rd_pend_ff <= 1'b1;
          rd_wait_ff <= fpo_pkg::RD_WAIT;
          hreadyout_ff <= 1'b0;
        end else begin
          hrdata_ff <= reg_rd(i_haddr[7:0]);
        end
      end
    end
  end

  // address and control registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cmd_addr_ff <= '0;
      ctrl_ff <= fpo_pkg::CTRL_INIT;
    end else if (wr_strobe) begin
      case (dp_addr_ff)
        fpo_pkg::REG_ADDR: cmd_addr_ff <= i_hwdata[ADDR_W-1:0];
        fpo_pkg::REG_CTRL: ctrl_ff <= i_hwdata[2:0];
        default: ;
      endcase
    end
  end

  // command machine; flash reset aborts it and clears status
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || flash_rst) begin
      state_ff <= fpo_pkg::CS_IDLE; // RULE19 RULE17
      prog_err_ff <= 1'b0; // RULE18
      lock_err_ff <= 1'b0; // RULE18
      setup_blk_ff <= '0;
      busy_cnt_ff <= '0;
      otp_widx_ff <= 8'h00;
      otp_wdata_ff <= 16'hFFFF;
    end else begin
      case (state_ff)
        fpo_pkg::CS_IDLE: begin
          if (cmd_we) begin
            case (cmd_word)
              fpo_pkg::CMD_LOCK_SETUP: begin
                state_ff <= fpo_pkg::CS_LOCK_SETUP; // RULE1 RULE23
                setup_blk_ff <= cur_blk; // RULE27
              end
              fpo_pkg::CMD_OTP_SETUP: begin
                state_ff <= fpo_pkg::CS_OTP_SETUP; // RULE12
              end
              fpo_pkg::CMD_CLEAR_STATUS: begin
                prog_err_ff <= 1'b0;
                lock_err_ff <= 1'b0;
              end
              default: ;
            endcase
          end
        end
        fpo_pkg::CS_LOCK_SETUP: begin
          // any second word ends the sequence
          if (cmd_we) begin
            state_ff <= fpo_pkg::CS_IDLE; // RULE27
          end
        end
        fpo_pkg::CS_OTP_SETUP: begin
          if (cmd_we) begin
            if (!in_otp) begin
              prog_err_ff <= 1'b1; // RULE10
              state_ff <= fpo_pkg::CS_IDLE;
            end else if (otp_word_locked(otp_idx, otp_lock0,
                                         otp_lock1)) begin
              prog_err_ff <= 1'b1; // RULE9
              lock_err_ff <= 1'b1; // RULE9 RULE8
              state_ff <= fpo_pkg::CS_IDLE;
            end else begin
              state_ff <= fpo_pkg::CS_OTP_BUSY; // RULE12
              busy_cnt_ff <= BCW'(OTP_PROG_CYC - 1);
              otp_widx_ff <= otp_idx;
              otp_wdata_ff <= cmd_word; // RULE11
            end
          end
        end
        fpo_pkg::CS_OTP_BUSY: begin
          // suspend words are simply not looked at here
          if (busy_cnt_ff == '0) begin
            state_ff <= fpo_pkg::CS_IDLE; // RULE14
          end else begin
            busy_cnt_ff <= busy_cnt_ff - BCW'(1);
          end
        end
        default: state_ff <= fpo_pkg::CS_IDLE;
      endcase
    end
  end

  // per-partition read mode
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || flash_rst) begin
      for (int p = 0; p < NUM_PARTS; p++) begin
        mode_ff[p] <= fpo_pkg::RM_ARRAY; // RULE18
      end
    end else if (cmd_we) begin
      if (state_ff == fpo_pkg::CS_IDLE) begin
        case (cmd_word)
          fpo_pkg::CMD_READ_ARRAY: mode_ff[cur_part] <= fpo_pkg::RM_ARRAY;
          fpo_pkg::CMD_READ_STATUS: mode_ff[cur_part] <= fpo_pkg::RM_STATUS;
          fpo_pkg::CMD_IDENTIFICATION_READ: mode_ff[cur_part] <= fpo_pkg::RM_ID; // RULE15
          fpo_pkg::CMD_LOCK_SETUP: mode_ff[cur_part] <= fpo_pkg::RM_STATUS;
          fpo_pkg::CMD_OTP_SETUP: begin
            mode_ff[cur_part] <= fpo_pkg::RM_STATUS; // RULE13
          end
          default: ;
        endcase
      end else if (state_ff == fpo_pkg::CS_OTP_BUSY &&
                   cmd_word == fpo_pkg::CMD_READ_STATUS) begin
        mode_ff[cur_part] <= fpo_pkg::RM_STATUS;
      end
    end
  end

  // main-array lock and lock-down bits
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || flash_rst) begin
      lock_ff <= '1; // RULE24
      ldn_ff <= '0; // RULE24
    end else begin
      // asserting write protect relocks every locked-down block
      if (wp_on) begin
        lock_ff <= lock_ff | ldn_ff; // RULE25
      end
      if (cmd_we && state_ff == fpo_pkg::CS_LOCK_SETUP &&
          cur_blk == setup_blk_ff) begin // RULE27
        case (cmd_word)
          fpo_pkg::CMD_LOCK: lock_ff[cur_blk] <= 1'b1; // RULE23
          fpo_pkg::CMD_UNLOCK: begin
            if (!(ldn_ff[cur_blk] && wp_on)) begin
              lock_ff[cur_blk] <= 1'b0; // RULE23 RULE25
            end
          end
          fpo_pkg::CMD_LOCKDOWN: ldn_ff[cur_blk] <= 1'b1; // RULE1
          default: ;
        endcase
      end
    end
  end

  // reset completion time: long when an operation was aborted
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rst_prev_ff <= 1'b0;
      rst_cnt_ff <= '0;
      rst_done_ff <= 1'b1;
    end else begin
      rst_prev_ff <= flash_rst;
      if (flash_rst && !rst_prev_ff) begin
        rst_done_ff <= 1'b0;
        if (state_ff == fpo_pkg::CS_OTP_BUSY) begin
          rst_cnt_ff <= RCW'(RST_ABORT_CYC - 1); // RULE21
        end else begin
          rst_cnt_ff <= RCW'(fpo_pkg::RST_MIN_CYC - 1); // RULE21
        end
      end else if (flash_rst) begin
        if (rst_cnt_ff != '0) begin
          rst_cnt_ff <= rst_cnt_ff - RCW'(1);
        end else begin
          rst_done_ff <= 1'b1;
        end
      end
    end
  end

  // pin enables and the array program/erase inhibit
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      data_oe_ff <= 1'b0;
      wait_oe_ff <= 1'b0;
      pe_inhibit_ff <= 1'b1;
    end else begin
      data_oe_ff <= ~flash_rst; // RULE17
      wait_oe_ff <= ~flash_rst; // RULE17
      pe_inhibit_ff <= ~vpp_ok | flash_rst; // RULE16
    end
  end

  assign o_hrdata = hrdata_ff;
  assign o_hreadyout = hreadyout_ff;
  assign o_hresp = hresp_ff;
  assign o_data_oe = data_oe_ff;
  assign o_wait_oe = wait_oe_ff;
  assign o_pe_inhibit = pe_inhibit_ff;
endmodule : fpo_top

/* dv/fpo_top_sva.sv */
// checker of bus wait states and pin enables of fpo_top
// assumes hready is tied back to hreadyout
`timescale 1ns/10ps
module fpo_top_sva (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_data_oe,
  input wire logic o_wait_oe,
  input wire logic o_pe_inhibit
);
  logic ap_ff; // an address phase is pending
  logic [7:0] ad_ff; // its register offset
  logic wr_ff; // its direction
  logic [2:0] ctl_ff; // shadow of the control register
  logic take; // address phase accepted now
  assign take = i_hready && i_hsel && i_htrans[1];
  // shadow control writes so pin intent is known here
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ap_ff <= 1'b0;
      ctl_ff <= fpo_pkg::CTRL_INIT;
    end else if (i_hready) begin
      ap_ff <= take;
      if (ap_ff && wr_ff && ad_ff == fpo_pkg::REG_CTRL) begin
        ctl_ff <= i_hwdata[2:0];
      end
    end
  end
  // address phase details, no reset needed
  always_ff @(posedge i_clk) begin
    if (i_hready) begin
      ad_ff <= i_haddr[7:0];
      wr_ff <= i_hwrite;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  oe_pair_a: assert property (o_data_oe == o_wait_oe)
    else $error("data and wait enables differ");
  oe_off_a: assert property (!ctl_ff[0] [*2] |-> !o_data_oe)
    else $error("pins driven in flash reset");
  oe_on_a: assert property (ctl_ff[0] [*3] |-> o_data_oe)
    else $error("pins idle out of reset");
  low_supply_a: assert property (!ctl_ff[2] [*2] |-> o_pe_inhibit)
    else $error("writes allowed on low supply");
  rst_inhib_a: assert property (!ctl_ff[0] [*2] |-> o_pe_inhibit)
    else $error("writes allowed in flash reset");
  armed_a: assert property ((ctl_ff[0] && ctl_ff[2]) [*3] |-> !o_pe_inhibit)
    else $error("writes blocked with good supply");
  read_wait_a: assert property (take && !i_hwrite &&
    i_haddr[7:0] == fpo_pkg::REG_DATA |=> !o_hreadyout [*2] ##1 o_hreadyout)
    else $error("flash read wait wrong");
  zero_wait_a: assert property (take && (i_hwrite ||
    i_haddr[7:0] != fpo_pkg::REG_DATA) |=> o_hreadyout)
    else $error("register access stalled");
  okay_resp_a: assert property (!o_hresp)
    else $error("bus response not okay");
  cover property (take && !i_hwrite && i_haddr[7:0] == fpo_pkg::REG_DATA);
  cover property (!ctl_ff[0]);
  cover property (ctl_ff[2] && !ctl_ff[1]);
endmodule : fpo_top_sva
bind fpo_top fpo_top_sva chk_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
  .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
  .o_hresp(o_hresp), .o_data_oe(o_data_oe), .o_wait_oe(o_wait_oe),
  .o_pe_inhibit(o_pe_inhibit));

/* dv/fpo_host.sv */
// ahb-lite master standing in for the host processor
// assumes one slave whose hreadyout is the bus hready
`timescale 1ns/10ps
module fpo_host (
  input wire logic i_clk,
  input wire logic i_hready,
  input wire logic [31:0] i_hrdata,
  output logic o_hsel,
  output logic [31:0] o_haddr,
  output logic [1:0] o_htrans,
  output logic o_hwrite,
  output logic [2:0] o_hsize,
  output logic [31:0] o_hwdata
);
  // idle bus at time zero, word size only
  initial begin
    o_hsel = 1'b1;
    o_haddr = 32'h0;
    o_htrans = 2'h0;
    o_hwrite = 1'b0;
    o_hsize = 3'h2;
    o_hwdata = 32'h0;
  end
  // one single transfer; waits on hready, never on a cycle count
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
    @(posedge i_clk);
    o_haddr <= {24'h0, a};
    o_htrans <= 2'h2;
    o_hwrite <= w;
    do @(posedge i_clk); while (i_hready !== 1'b1);
    o_htrans <= 2'h0;
    o_hwdata <= d;
    do @(posedge i_clk); while (i_hready !== 1'b1);
    q = i_hrdata;
  endtask : xfer
endmodule : fpo_host

/* dv/flash_protection_otp_reset_bench.sv */
// self-checking bench of fpo_top driven through the host model
// assumes short program and abort counts set below
`timescale 1ns/10ps
module flash_protection_otp_reset_bench;
  logic clk, rst, hsel, hwrite, hrdy, hresp, doe, woe, inh;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q, seed, r;
  logic [25:0] b, c;
  logic [15:0] v;
  int bad_count, checks;
  fpo_top #(.OTP_PROG_CYC(40), .RST_ABORT_CYC(20)) uut (.i_clk(clk),
    .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
    .o_data_oe(doe), .o_wait_oe(woe), .o_pe_inhibit(inh));
  fpo_host host (.i_clk(clk), .i_hready(hrdy), .i_hrdata(hrdata),
    .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite),
    .o_hsize(hsize), .o_hwdata(hwdata));
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task conclude();
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  // one flash bus write cycle at a word address
  task cmd(input logic [25:0] a, input logic [15:0] w);
    host.xfer(1'b1, fpo_pkg::REG_ADDR, {6'h0, a}, q);
    host.xfer(1'b1, fpo_pkg::REG_DATA, {16'h0, w}, q);
  endtask : cmd
  task rdf(input logic [25:0] a);
    host.xfer(1'b1, fpo_pkg::REG_ADDR, {6'h0, a}, q);
    host.xfer(1'b0, fpo_pkg::REG_DATA, 32'h0, q);
  endtask : rdf
  task lk(input logic [1:0] e);
    cmd(b, fpo_pkg::CMD_IDENTIFICATION_READ);
    rdf(b + 26'h2);
    chk("lock bits", q, {30'h0, e});
  endtask : lk
  task ord(input logic [7:0] i, input logic [15:0] e);
    cmd(26'h0, fpo_pkg::CMD_IDENTIFICATION_READ);
    rdf(26'h80 + i);
    chk("otp word", q, {16'h0, e});
  endtask : ord
  // setup, data, a suspend that must be ignored, then wait for ready
  task otp(input logic [7:0] i, input logic [15:0] d, input logic [7:0] e);
    cmd(26'h0, fpo_pkg::CMD_OTP_SETUP);
    rdf(26'h0);
    chk("setup mode", q[7:0], 32'h80);
    cmd(26'h80 + i, d);
    cmd(26'h0, fpo_pkg::CMD_SUSPEND);
    for (int n = 0; n < 30; n++) begin
      host.xfer(1'b0, fpo_pkg::REG_STATUS, 32'h0, q);
      if (!q[fpo_pkg::STAT_BUSY_BIT]) break;
    end
    chk("status", q[7:0], {24'h0, e});
    cmd(26'h0, fpo_pkg::CMD_CLEAR_STATUS);
  endtask : otp
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude();
  end
  initial begin
    logic [15:0] cf [4] = '{16'h00D0, 16'h0001, 16'h002F, 16'h00D0};
    logic [1:0] ex [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    rst = 1'b1;
    seed = 32'hCB37E8A1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    host.xfer(1'b0, fpo_pkg::REG_CTRL, 32'h0, q);
    chk("ctrl reset", q, 32'h3);
    host.xfer(1'b1, 8'h10, 32'hFFFFFFFF, q);
    host.xfer(1'b0, 8'h10, 32'h0, q);
    chk("unmapped", q, 32'h0);
    host.xfer(1'b0, fpo_pkg::REG_STATUS, 32'h0, q);
    chk("status reset", q[7:0], 32'h80);
    host.xfer(1'b1, fpo_pkg::REG_CTRL, 32'h7, q);
    r = xs();
    b = {r[8:0], 17'h0};
    c = b ^ 26'h20000;
    lk(2'h1);
    cmd(c, 16'h0060);
    cmd(c, 16'h00D0);
    cmd(b, 16'h0060);
    cmd(c, 16'h0001);
    b = c;
    lk(2'h0);
    b = c ^ 26'h20000;
    for (int i = 0; i < 4; i++) begin
      cmd(b, fpo_pkg::CMD_LOCK_SETUP);
      cmd(b, cf[i]);
      lk(ex[i]);
    end
    host.xfer(1'b1, fpo_pkg::REG_CTRL, 32'h5, q);
    lk(2'h3);
    cmd(b, fpo_pkg::CMD_LOCK_SETUP);
    cmd(b, fpo_pkg::CMD_UNLOCK);
    lk(2'h3);
    ord(8'd0, 16'hFFFE);
    otp(8'd1, 16'h0000, 8'h92);
    otp(8'd138, 16'h0000, 8'h90);
    v = 16'hFFFF;
    for (int k = 0; k < 3; k++) begin
      r = xs();
      v = v & r[15:0];
      otp(8'd10, r[15:0], 8'h80);
      ord(8'd10, v);
    end
    otp(8'd0, 16'hFFFD, 8'h80);
    otp(8'd5, 16'h0000, 8'h92);
    otp(8'd0, 16'hFFFF, 8'h80);
    ord(8'd0, 16'hFFFC);
    cmd(26'h0, fpo_pkg::CMD_OTP_SETUP);
    cmd(26'h80 + 26'd20, 16'h0000);
    host.xfer(1'b1, fpo_pkg::REG_CTRL, 32'h4, q);
    rdf(26'h0);
    chk("read in reset", q, 32'h0);
    host.xfer(1'b0, fpo_pkg::REG_STATUS, 32'h0, q);
    chk("abort still busy", q[8], 1'b0);
    for (int n = 0; n < 13; n++) begin
      host.xfer(1'b0, fpo_pkg::REG_STATUS, 32'h0, q);
      if (q[fpo_pkg::STAT_RST_DONE_BIT]) break;
    end
    chk("abort reset", q[8:0], 32'h180);
    repeat (fpo_pkg::RST_MIN_CYC) @(posedge clk);
    host.xfer(1'b1, fpo_pkg::REG_CTRL, 32'h7, q);
    lk(2'h1);
    conclude();
  end
endmodule : flash_protection_otp_reset_bench
